// ---- src/pcr_pkg.sv ----
/*
  constants, field layouts and carrier types for the type-zero
  configuration header register bank.
  assumes a single pci clock domain and dword-aligned byte addresses.
*/
package pcr_pkg;

  // ----------------------------------------------------------------
  // register byte addresses (dword aligned)
  // ----------------------------------------------------------------
  localparam logic [7:0]  PCR_OFF_CMD_STAT = 8'h04;
  localparam logic [7:0]  PCR_OFF_CLASS    = 8'h08;
  localparam logic [7:0]  PCR_OFF_MISC     = 8'h0C;
  localparam logic [7:0]  PCR_OFF_BAR0     = 8'h10;
  localparam logic [7:0]  PCR_BAR_STRIDE   = 8'h04;
  localparam int          PCR_MAX_BARS     = 6;

  // ----------------------------------------------------------------
  // reset values and fixed fields
  // ----------------------------------------------------------------
  localparam logic [15:0] PCR_CMD_RST      = 16'h0000;
  localparam logic [15:0] PCR_STATUS_RST   = 16'h0400;
  localparam logic [23:0] PCR_CLASS_RST    = 24'hFF0000;
  localparam logic [7:0]  PCR_LINE_RST     = 8'h00;
  localparam logic [7:0]  PCR_TENURE_RST   = 8'h00;
  localparam logic [7:0]  PCR_HEADER_VAL   = 8'h00;
  localparam logic [1:0]  PCR_DEVSEL_SLOW  = 2'h2;
  localparam logic [31:0] PCR_BAR_RST      = 32'h00000000;

  // ----------------------------------------------------------------
  // field masks and bit positions
  // ----------------------------------------------------------------
  localparam logic [15:0] PCR_CMD_WMASK    = 16'h0157;
  localparam logic [15:0] PCR_CMD_MSTR     = 16'h0014;
  localparam logic [15:0] PCR_ST_STICKY    = 16'hF900;
  localparam logic [15:0] PCR_ST_MSTR      = 16'h2100;
  localparam logic [7:0]  PCR_TENURE_WMASK = 8'hF8;
  localparam int          PCR_CMD_PERR_EN  = 6;
  localparam int          PCR_CMD_SERR_EN  = 8;
  localparam int          PCR_ST_PAR_REP   = 8;
  localparam int          PCR_ST_TABT_SIG  = 11;
  localparam int          PCR_ST_TABT_RCV  = 12;
  localparam int          PCR_ST_MABT      = 13;
  localparam int          PCR_ST_SERR      = 14;
  localparam int          PCR_ST_PERR_DET  = 15;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] data;
  } pcr_cfg_req_t;

  typedef struct packed {
    logic mstr_rd_perr;
    logic tgt_wr_perr;
    logic tabort_issued;
    logic tabort_rcvd;
    logic mabort;
    logic addr_perr;
    logic data_perr;
  } pcr_evt_t;

  typedef struct packed {
    logic perr_rep;
    logic tabort_sig;
    logic tabort_rcvd;
    logic mabort_rcvd;
    logic serr_sig;
    logic perr_det;
  } pcr_flags_t;

  // writable base bits: the run of ones from bit 31 down; an i/o
  // window always decodes 31..8 so it never spans more than 256 bytes
  function automatic logic [31:0] pcr_wmask(input logic [31:0] c);
    logic [31:0] m;
    logic        run;
    int          lo;
    m   = '0;
    run = 1'b1;
    lo  = c[0] ? 2 : 4;
    for (int b = 31; b >= 2; b--) begin
      if (b >= lo) begin
        run  = run & c[b];
        m[b] = run;
      end
    end
    if (c[0]) begin
      m[31:8] = '1;
    end
    return m;
  endfunction

  // fixed low bits: memory keeps type bit 1 and prefetch, i/o reads 01
  function automatic logic [31:0] pcr_fixed(input logic [31:0] c);
    logic [31:0] f;
    f = '0;
    if (c[0]) begin
      f[0] = 1'b1;
    end else begin
      f[1] = c[1];
      f[3] = c[3];
    end
    return f;
  endfunction

endpackage : pcr_pkg

// ---- src/pcr_config_regs.sv ----
/*
  type-zero configuration header register bank: command, status,
  class, revision, line size, bus tenure timer, header and windows.
  assumes the transaction logic of the core presents decoded config
  accesses and bus events on the same pci clock, one cycle each.
*/
`timescale 1ns/1ns
// Function
// - serr needs serr enable and parity enable
// - target-only build ties master bits low
// - status write-one clears, never sets
// - status resets to 0400
// - bit 8 parity reported, gated by bit 6
// - bits 10..9 fixed slow timing 10
// - bit 11 set on local-requested target abort
// - bit 12 set on received target abort
// - bit 13 set on master abort
// - bit 14 set when serr driven
// - bit 15 set on address or data parity error
// - class code read-only build constant
// - line size read/write with master enabled, driven to local side
// - tenure timer low bits zero, reset 00
// - tenure count decrements each clock as master
// - header type reads 00
// - up to six windows by parameter, each with its own BAR_CFG code
// - window bit 0 selects memory or i/o
// - memory type bits limited to two codes
// - bit 3 reports prefetchable from constant
// - writable base bits from leading ones run
// - i/o bit 1 zero, at most 256 bytes
// - unimplemented locations read zero, ignore writes
// - bit 6 enables data parity error output
module pcr_config_regs #(
  parameter bit                 MASTER_EN          = 1'b1,
  parameter int                 window_count_param = 6,
  // arbitrary neutral value
  parameter logic [7:0]         revision_param     = 8'h01,
  parameter logic [23:0]        CLASS_CODE         = pcr_pkg::PCR_CLASS_RST,
  parameter logic [5:0][31:0]   BAR_CFG            = {32'h0, 32'h0,
                                                      32'h0, 32'h0,
                                                      32'hFFFFFFC1,
                                                      32'hFFC00008}
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_b_i,
  input  wire pcr_pkg::pcr_cfg_req_t cfg_req_i,
  output logic [31:0]               cfg_rdata_o,
  output logic                      cfg_ack_o,
  input  wire pcr_pkg::pcr_evt_t    evt_i,
  input  wire logic                 local_abort_request_n_i,
  input  wire logic                 mstr_start_i,
  input  wire logic                 mstr_busy_i,
  output logic                      serr_o,
  output logic                      perr_o,
  output pcr_pkg::pcr_flags_t       flags_o,
  output logic [15:0]               cmd_o,
  output logic [7:0]                line_size_o,
  output logic [7:0]                tenure_left_o,
  output logic                      tenure_expired_o
);
  import pcr_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0]      cmd_reg;
  logic [15:0]      status_reg;
  logic [15:0]      status_next;
  logic [7:0]       line_reg;
  logic [7:0]       tenure_reg;
  logic [7:0]       count_reg;
  logic             serr_reg;
  logic             perr_reg;
  logic             serr_next;
  logic [31:0]      rdata_reg;
  logic             ack_reg;
  logic [31:0]      rd_word;
  logic [5:0][31:0] bar_rd;
  logic [5:0]       bar_hit;
  logic [15:0]      cmd_mask;
  logic [15:0]      st_mask;
  logic [15:0]      st_set;
  logic [15:0]      st_clr;
  logic             wr_cs;
  logic             wr_misc;

  assign cmd_mask = MASTER_EN ? PCR_CMD_WMASK
                              : (PCR_CMD_WMASK & ~PCR_CMD_MSTR);
  assign st_mask  = MASTER_EN ? PCR_ST_STICKY
                              : (PCR_ST_STICKY & ~PCR_ST_MSTR);
  assign wr_cs    = cfg_req_i.wr && (cfg_req_i.addr == PCR_OFF_CMD_STAT);
  assign wr_misc  = cfg_req_i.wr && (cfg_req_i.addr == PCR_OFF_MISC);

  // ----------------------------------------------------------------
  // command register
  // ----------------------------------------------------------------
  // unused command bits
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_reg <= PCR_CMD_RST;
    end else if (wr_cs) begin
      if (cfg_req_i.be[0]) begin
        cmd_reg[7:0] <= cfg_req_i.data[7:0] & cmd_mask[7:0];
      end
      if (cfg_req_i.be[1]) begin
        cmd_reg[15:8] <= cfg_req_i.data[15:8] & cmd_mask[15:8];
      end
    end
  end
  assign cmd_o = cmd_reg;

  // ----------------------------------------------------------------
  // error outputs
  // ----------------------------------------------------------------
  // serr gated by both enables
  assign serr_next = evt_i.addr_perr && cmd_reg[PCR_CMD_SERR_EN]
                     && cmd_reg[PCR_CMD_PERR_EN];
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serr_reg <= 1'b0;
      perr_reg <= 1'b0;
    end else begin
      serr_reg <= serr_next;
      perr_reg <= evt_i.data_perr && cmd_reg[PCR_CMD_PERR_EN];
    end
  end
  assign serr_o = serr_reg;
  assign perr_o = perr_reg;

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  always_comb begin
    st_set = '0;
    // parity reported only with bit 6
    st_set[PCR_ST_PAR_REP]  = (evt_i.mstr_rd_perr || evt_i.tgt_wr_perr)
                              && cmd_reg[PCR_CMD_PERR_EN];
    st_set[PCR_ST_TABT_SIG] = evt_i.tabort_issued && !local_abort_request_n_i;
    st_set[PCR_ST_TABT_RCV] = evt_i.tabort_rcvd;
    st_set[PCR_ST_MABT]     = evt_i.mabort;
    st_set[PCR_ST_SERR]     = serr_next;
    st_set[PCR_ST_PERR_DET] = evt_i.addr_perr || evt_i.data_perr;
    st_clr = '0;
    if (wr_cs) begin
      st_clr[7:0]  = cfg_req_i.be[2] ? cfg_req_i.data[23:16] : 8'h00;
      st_clr[15:8] = cfg_req_i.be[3] ? cfg_req_i.data[31:24] : 8'h00;
    end
    // write-one clear; a set in the same cycle wins
    status_next = ((status_reg & ~st_clr) | st_set) & st_mask;
    status_next[10:9] = PCR_DEVSEL_SLOW;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_reg <= PCR_STATUS_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  assign flags_o.perr_rep    = status_reg[PCR_ST_PAR_REP];
  assign flags_o.tabort_sig  = status_reg[PCR_ST_TABT_SIG];
  assign flags_o.tabort_rcvd = status_reg[PCR_ST_TABT_RCV];
  assign flags_o.mabort_rcvd = status_reg[PCR_ST_MABT];
  assign flags_o.serr_sig    = status_reg[PCR_ST_SERR];
  assign flags_o.perr_det    = status_reg[PCR_ST_PERR_DET];

  // ----------------------------------------------------------------
  // line size and bus tenure timer
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_reg   <= PCR_LINE_RST;
      tenure_reg <= PCR_TENURE_RST;
    end else if (wr_misc && MASTER_EN) begin
      if (cfg_req_i.be[0]) begin
        line_reg <= cfg_req_i.data[7:0];
      end
      if (cfg_req_i.be[1]) begin
        tenure_reg <= cfg_req_i.data[15:8] & PCR_TENURE_WMASK;
      end
    end
  end
  assign line_size_o = line_reg;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_reg <= PCR_TENURE_RST;
    end else if (mstr_start_i) begin
      count_reg <= tenure_reg;
    end else if (mstr_busy_i && count_reg != 8'h00) begin
      count_reg <= count_reg - 8'h01;
    end
  end
  assign tenure_left_o    = count_reg;
  // the master must give up the bus once this rises and grant is gone
  assign tenure_expired_o = mstr_busy_i && (count_reg == 8'h00);

  // ----------------------------------------------------------------
  // address windows
  // ----------------------------------------------------------------
  // one slice per window
  generate
    for (genvar n = 0; n < PCR_MAX_BARS; n++) begin : g_bar
      localparam logic [31:0] WMASK = pcr_wmask(BAR_CFG[n]);
      localparam logic [31:0] FIXED = pcr_fixed(BAR_CFG[n]);
      localparam logic [7:0]  OFF   = PCR_OFF_BAR0
                                      + PCR_BAR_STRIDE * 8'(n);
      if (n < window_count_param) begin : g_on
        logic [31:0] base_reg;
        assign bar_hit[n] = (cfg_req_i.addr == OFF);
        always_ff @(posedge clock_i or negedge rst_b_i) begin
          if (!rst_b_i) begin
            base_reg <= PCR_BAR_RST;
          end else if (cfg_req_i.wr && bar_hit[n]) begin
            for (int l = 0; l < 4; l++) begin
              if (cfg_req_i.be[l]) begin
                base_reg[8*l +: 8] <= cfg_req_i.data[8*l +: 8]
                                      & WMASK[8*l +: 8];
              end
            end
          end
        end
        // type bit, type code, prefetch, i/o
        assign bar_rd[n] = (base_reg & WMASK) | FIXED;
      end else begin : g_off
        assign bar_hit[n] = 1'b0;
        assign bar_rd[n]  = '0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    case (cfg_req_i.addr)
      PCR_OFF_CMD_STAT: rd_word = {status_reg, cmd_reg};
      PCR_OFF_CLASS:    rd_word = {CLASS_CODE, revision_param};
      PCR_OFF_MISC:     rd_word = {8'h00, PCR_HEADER_VAL,
                                   tenure_reg, line_reg};
      default: begin
        for (int k = 0; k < PCR_MAX_BARS; k++) begin
          if (bar_hit[k]) begin
            rd_word = bar_rd[k];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= '0;
      ack_reg   <= 1'b0;
    end else begin
      ack_reg <= cfg_req_i.rd || cfg_req_i.wr;
      if (cfg_req_i.rd) begin
        rdata_reg <= rd_word;
      end
    end
  end
  assign cfg_rdata_o = rdata_reg;
  assign cfg_ack_o   = ack_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_clear_st14;
    wr_cs && cfg_req_i.be[3] && cfg_req_i.data[30] && !serr_next;
  endsequence
  sequence s_read_misc;
    cfg_req_i.rd && cfg_req_i.addr == PCR_OFF_MISC;
  endsequence

  a_serr_gate: assert property (
    serr_o |-> $past(evt_i.addr_perr && cmd_reg[8] && cmd_reg[6]))
    else $error("serr without both enables");
  a_st_clear: assert property (
    s_clear_st14 |=> !status_reg[14])
    else $error("status bit 14 not cleared");
  a_st_keep: assert property (
    wr_cs && cfg_req_i.be[3] && !cfg_req_i.data[31] && status_reg[15]
    |=> status_reg[15])
    else $error("status bit 15 lost on zero write");
  a_devsel_code: assert property (
    status_reg[10:9] == 2'h2)
    else $error("select timing code wrong");
  a_serr_flag: assert property (
    serr_o |-> status_reg[14] && flags_o.serr_sig)
    else $error("serr flag not set with output");
  a_perr_det: assert property (
    evt_i.data_perr |=> status_reg[15])
    else $error("parity detect flag missed");
  a_tenure_low: assert property (
    s_read_misc |=> cfg_ack_o && cfg_rdata_o[10:8] == 3'h0)
    else $error("tenure low bits not zero");
  a_tenure_dec: assert property (
    mstr_busy_i && !mstr_start_i && count_reg != 8'h00
    |=> count_reg == $past(count_reg) - 8'h01)
    else $error("tenure count did not decrement");
  a_perr_gate: assert property (
    evt_i.data_perr && !cmd_reg[6] |=> !perr_o)
    else $error("parity output without enable");
  a_unmapped_zero: assert property (
    cfg_req_i.rd && cfg_req_i.addr == 8'h3C |=> cfg_rdata_o == 32'h0)
    else $error("unmapped word not zero");
  a_tabort_sig: assert property (
    evt_i.tabort_issued && !local_abort_request_n_i |=> status_reg[11])
    else $error("abort signalled flag missed");
  a_rcvd_flag: assert property (
    evt_i.tabort_rcvd |=> flags_o.tabort_rcvd)
    else $error("received abort flag missed");
  a_mabort_flag: assert property (
    evt_i.mabort && MASTER_EN |=> flags_o.mabort_rcvd)
    else $error("master abort flag missed");
  a_tenure_load: assert property (
    mstr_start_i |=> count_reg == $past(tenure_reg))
    else $error("tenure count not loaded");

endmodule // pcr_config_regs

// ---- tb/pcr_host_model.sv ----
/*
  host model for the configuration register bank: issues one config
  read or write at a time and collects the registered answer.
  assumes the bank acks exactly one cycle after taking a request.
*/
`timescale 1ns/1ns
module pcr_host_model (
  input  wire logic                   clock_i,
  output pcr_pkg::pcr_cfg_req_t       req_o,
  input  wire logic [31:0]            rdata_i,
  input  wire logic                   ack_i
);
  import pcr_pkg::*;

  initial req_o = '0;

  // ----------------------------------------------------------------
  // one access: request for one cycle, answer read at falling edges
  // ----------------------------------------------------------------
  task automatic xfer(input  logic        r,
                      input  logic        w,
                      input  logic [7:0]  a,
                      input  logic [3:0]  be,
                      input  logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(negedge clock_i);
    req_o.rd   = r;
    req_o.wr   = w;
    req_o.addr = a;
    req_o.be   = be;
    req_o.data = d;
    @(negedge clock_i);
    // idle lines carry the inverse so a stale value never matches
    req_o.rd   = 1'b0;
    req_o.wr   = 1'b0;
    req_o.addr = ~a;
    req_o.be   = ~be;
    req_o.data = ~d;
    n = 0;
    while (ack_i !== 1'b1 && n < 8) begin
      @(negedge clock_i);
      n++;
    end
    q = (n < 8) ? rdata_i : 'x;
  endtask

endmodule // pcr_host_model

// ---- tb/tb.sv ----
/*
  self-checking bench for the configuration register bank.
  assumes default build parameters: master enabled, six windows,
  window 0 memory FFC00008, window 1 i/o FFFFFFC1, others unused.
  a second, target-only copy has one window of code FFF00006.
*/
`timescale 1ns/1ns
module tb;
  import pcr_pkg::*;

  logic                  clock     = 1'b0;
  logic                  rst_b     = 1'b0;
  pcr_cfg_req_t          req;
  logic [31:0]           rdata;
  logic                  ack;
  pcr_evt_t              evt       = '0;
  logic                  abort_n   = 1'b1;
  logic                  mstart    = 1'b0;
  logic                  mbusy     = 1'b0;
  logic                  serr;
  logic                  perr;
  pcr_flags_t            flags;
  logic [15:0]           cmd;
  logic [7:0]            line_size;
  logic [7:0]            tenure;
  logic                  expired;
  logic [31:0]           rdata_t;
  pcr_flags_t            flags_t;
  logic                  serr_seen;
  logic                  perr_seen;
  int                    n_errors  = 0;
  int                    n_checks  = 0;

  always #20 clock = ~clock;

  pcr_host_model i_host (.clock_i(clock), .req_o(req), .rdata_i(rdata),
                         .ack_i(ack));

  pcr_config_regs i_dut (
    .clock_i                 (clock),
    .rst_b_i                 (rst_b),
    .cfg_req_i               (req),
    .cfg_rdata_o             (rdata),
    .cfg_ack_o               (ack),
    .evt_i                   (evt),
    .local_abort_request_n_i (abort_n),
    .mstr_start_i            (mstart),
    .mstr_busy_i             (mbusy),
    .serr_o                  (serr),
    .perr_o                  (perr),
    .flags_o                 (flags),
    .cmd_o                   (cmd),
    .line_size_o             (line_size),
    .tenure_left_o           (tenure),
    .tenure_expired_o        (expired)
  );

  // target-only build, one window whose type code asks for bit 2;
  // it shares the request lines, so its read data is checked directly
  pcr_config_regs #(
    .MASTER_EN          (1'b0),
    .window_count_param (1),
    .BAR_CFG            ({32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                          32'hFFF00006})
  ) i_dut_tgt (
    .clock_i                 (clock),
    .rst_b_i                 (rst_b),
    .cfg_req_i               (req),
    .cfg_rdata_o             (rdata_t),
    .cfg_ack_o               (),
    .evt_i                   (evt),
    .local_abort_request_n_i (abort_n),
    .mstr_start_i            (mstart),
    .mstr_busy_i             (mbusy),
    .serr_o                  (),
    .perr_o                  (),
    .flags_o                 (flags_t),
    .cmd_o                   (),
    .line_size_o             (),
    .tenure_left_o           (),
    .tenure_expired_o        ()
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_host.xfer(1'b1, 1'b0, a, 4'hF, 32'h00000000, d);
    chk(d, exp, "register read");
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b0, 1'b1, a, be, d, q);
  endtask

  // event bits: mstr_rd_perr tgt_wr_perr tabort_issued tabort_rcvd
  // mabort addr_perr data_perr; error pins sampled the cycle after
  task automatic fire(input logic [6:0] e);
    @(negedge clock);
    evt = e;
    @(negedge clock);
    evt = '0;
    serr_seen = serr;
    perr_seen = perr;
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #(4000 * 40);
    n_errors++;
    final_report();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clock);
    rst_b = 1'b1;
    rd(8'h04, 32'h04000000);
    rd(8'h08, 32'hFF000001);
    rd(8'h0C, 32'h00000000);
    rd(8'h10, 32'h00000008);
    chk(rdata_t, 32'h00000002, "memory type code");
    rd(8'h14, 32'h00000001);
    chk(rdata_t, 32'h00000000, "window count");
    rd(8'h00, 32'h00000000);
    rd(8'h28, 32'h00000000);
    rd(8'h3C, 32'h00000000);
    // writable bits only
    wr(8'h04, 4'h3, 32'hFFFFFFFF);
    rd(8'h04, 32'h04000157);
    chk(rdata_t, 32'h04000143, "target-only command");
    chk({16'h0000, cmd}, 32'h00000157, "command port");
    wr(8'h08, 4'hF, 32'h12345678);
    rd(8'h08, 32'hFF000001);
    wr(8'h0C, 4'hF, 32'hFFFFFFFF);
    rd(8'h0C, 32'h0000F8FF);
    chk(rdata_t, 32'h00000000, "target-only timer");
    chk({24'h0, line_size}, 32'h000000FF, "line size port");
    wr(8'h10, 4'hF, 32'hFFFFFFFF);
    rd(8'h10, 32'hFFC00008);
    chk(rdata_t, 32'hFFF00002, "prefetch bit clear");
    wr(8'h14, 4'hF, 32'hFFFFFFFF);
    rd(8'h14, 32'hFFFFFFC1);
    wr(8'h18, 4'hF, 32'hFFFFFFFF);
    rd(8'h18, 32'h00000000);
    // status events with parity and serr enables set
    wr(8'h04, 4'h3, 32'h00000140);
    fire(7'h02);
    chk({31'h0, serr_seen}, 32'h1, "serr pulse");
    fire(7'h01);
    chk({31'h0, perr_seen}, 32'h1, "perr pulse");
    fire(7'h40);
    fire(7'h10);
    rd(8'h04, 32'hC5000140);
    abort_n = 1'b0;
    fire(7'h10);
    abort_n = 1'b1;
    fire(7'h08);
    fire(7'h04);
    rd(8'h04, 32'hFD000140);
    chk(rdata_t, 32'hDC000140, "target-only status");
    chk({26'h0, flags}, 32'h0000003F, "flags port");
    chk({26'h0, flags_t}, 32'h0000001B, "target-only flags");
    wr(8'h04, 4'hC, 32'h40000000);
    rd(8'h04, 32'hBD000140);
    chk({26'h0, flags}, 32'h0000003D, "flags port");
    wr(8'h04, 4'hC, 32'hFFFF0000);
    rd(8'h04, 32'h04000140);
    // serr enable without parity enable, then both enables clear
    wr(8'h04, 4'h3, 32'h00000100);
    fire(7'h02);
    chk({31'h0, serr_seen}, 32'h0, "serr gated");
    rd(8'h04, 32'h84000100);
    wr(8'h04, 4'hF, 32'hFFFF0000);
    fire(7'h21);
    chk({31'h0, perr_seen}, 32'h0, "perr gated");
    rd(8'h04, 32'h84000000);
    // tenure countdown while master owns the bus
    wr(8'h0C, 4'h2, 32'h00001800);
    rd(8'h0C, 32'h000018FF);
    @(negedge clock);
    mstart = 1'b1;
    @(negedge clock);
    mstart = 1'b0;
    chk({24'h0, tenure}, 32'h00000018, "tenure load");
    mbusy = 1'b1;
    repeat (23) @(negedge clock);
    chk({23'h0, expired, tenure}, 32'h00000001, "tenure count");
    @(negedge clock);
    chk({23'h0, expired, tenure}, 32'h00000100, "tenure end");
    mbusy = 1'b0;
    // reset in mid-run
    @(negedge clock);
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    chk({cmd, line_size, tenure}, 32'h00000000, "reset ports");
    rst_b = 1'b1;
    rd(8'h04, 32'h04000000);
    rd(8'h10, 32'h00000008);
    final_report();
  end

endmodule // tb
